// *** logic/cpt_core.sv ***
// Codec power sequencing, transmit control registers and PCM serial link.
`timescale 1ns/1ns
module cpt_core (
    // System clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Codec master clock watched for activity
    input  wire logic        i_codec_mclk,
    // PCM link
    input  wire logic        i_pcm_bit_clock,
    input  wire logic        i_pcm_frame_sync,
    input  wire logic        i_pcm_serial_in,
    output logic             o_pcm_serial_out,
    output logic             o_pcm_serial_out_oe,
    // Analog controls
    output logic             o_powered,
    output logic             o_diff_earphone_driver,
    output logic             o_single_earphone_driver,
    output logic             o_mic_mute_bit,
    output logic             o_ear_mute,
    output logic             o_sidetone_mute,
    output logic [3:0]       o_tx_gain_code,
    output logic             o_extended_gain,
    output logic             o_linear_mode,
    output logic             o_alaw_mode
);

    //------------------------------------------------------------------
    // Register file
    //------------------------------------------------------------------
    cpt_pkg::cpt_pwr_t   pwr;
    cpt_pkg::cpt_txg_t   txg;
    logic [7:0]          fmt;
    logic [14:0]         tx_word;
    logic                tx_tgl;
    logic [14:0]         rx_word_sys;
    logic                rx_new;
    logic                mclk_ok;
    logic                tx_busy_s2;
    cpt_pkg::cpt_state_t state;
    logic                wr;
    logic                rd;
    logic                rx_evt;

    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
    assign rd = i_wb_cyc & i_wb_stb & ~i_wb_we & ~o_wb_ack;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
        end
    end

    // Writes are taken in any power state so settings precede power-up.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr <= cpt_pkg::RST_PWR; // see [R2]
            txg <= cpt_pkg::RST_TXG; // see [R12]
            fmt <= cpt_pkg::RST_FMT;
        end else if (wr && i_wb_sel[0]) begin // see [R3]
            if (i_wb_adr == cpt_pkg::ADR_PWR) begin
                pwr <= i_wb_dat[7:0];
            end
            if (i_wb_adr == cpt_pkg::ADR_TXG) begin
                txg.clk_override <= i_wb_dat[7];
                // A reserved code would select no defined stage, so it is dropped.
                if (i_wb_dat[2:1] != 2'b11) begin // see [R18]
                    txg.gain_code <= i_wb_dat[3:0];
                end
            end
            if (i_wb_adr == cpt_pkg::ADR_FMT) begin
                fmt <= {6'h00, i_wb_dat[1:0]}; // see [R9]
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_word <= 15'h0000;
            tx_tgl  <= 1'b0;
        end else if (wr && i_wb_adr == cpt_pkg::ADR_TXW) begin
            if (i_wb_sel[0]) begin
                tx_word[7:0] <= i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
                tx_word[14:8] <= i_wb_dat[14:8];
            end
            tx_tgl <= ~tx_tgl;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (rd) begin
            unique case (i_wb_adr)
                cpt_pkg::ADR_PWR:  o_wb_dat <= {24'h000000, pwr};
                cpt_pkg::ADR_TXG:  o_wb_dat <= {24'h000000, txg};
                cpt_pkg::ADR_FMT:  o_wb_dat <= {24'h000000, fmt};
                cpt_pkg::ADR_STAT: o_wb_dat <= {28'h0000000, rx_new, tx_busy_s2,
                                                mclk_ok, state == cpt_pkg::CPT_UP};
                cpt_pkg::ADR_TXW:  o_wb_dat <= {17'h00000, tx_word};
                cpt_pkg::ADR_RXW:  o_wb_dat <= {17'h00000, rx_word_sys};
                default:           o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Master clock watch
    //------------------------------------------------------------------
    logic       mc1;
    logic       mc2;
    logic       mc3;
    logic [9:0] mc_cnt;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mc1     <= 1'b0;
            mc2     <= 1'b0;
            mc3     <= 1'b0;
            mc_cnt  <= 10'h000;
            mclk_ok <= 1'b0;
        end else begin
            mc1 <= i_codec_mclk;
            mc2 <= mc1;
            mc3 <= mc2;
            if (mc2 != mc3) begin
                mc_cnt  <= 10'h000;
                mclk_ok <= 1'b1;
            end else if (mc_cnt == 10'(cpt_pkg::MCLK_LOSS_CYC)) begin
                mclk_ok <= 1'b0; // see [R6]
            end else begin
                mc_cnt <= mc_cnt + 10'h001;
            end
        end
    end

    //------------------------------------------------------------------
    // Power state
    //------------------------------------------------------------------
    logic want_up;
    assign want_up = pwr.power_on & (mclk_ok | txg.clk_override); // see [R5] see [R8]

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= cpt_pkg::CPT_DOWN;
        end else begin
            unique case (state)
                cpt_pkg::CPT_DOWN: if (want_up) state <= cpt_pkg::CPT_UP;
                cpt_pkg::CPT_UP:   if (!want_up) state <= cpt_pkg::CPT_DOWN; // see [R6]
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_powered                <= 1'b0;
            o_diff_earphone_driver   <= 1'b0;
            o_single_earphone_driver <= 1'b0;
            o_mic_mute_bit           <= 1'b0;
            o_ear_mute               <= 1'b0;
            o_sidetone_mute          <= 1'b0;
            o_tx_gain_code           <= 4'h0;
            o_extended_gain          <= 1'b0;
            o_linear_mode            <= 1'b0;
            o_alaw_mode              <= 1'b0;
        end else begin
            o_powered                <= state == cpt_pkg::CPT_UP;
            o_diff_earphone_driver   <= state == cpt_pkg::CPT_UP && pwr.diff_ear; // see [R4]
            o_single_earphone_driver <= state == cpt_pkg::CPT_UP && !pwr.diff_ear;
            o_mic_mute_bit           <= pwr.mic_mute_bit; // see [R10]
            o_ear_mute               <= pwr.ear_mute;
            o_sidetone_mute          <= pwr.sidetone_mute;
            o_tx_gain_code           <= txg.gain_code; // see [R11]
            o_extended_gain          <= !txg.gain_code[3];
            o_linear_mode            <= fmt[cpt_pkg::FMT_LINEAR];
            o_alaw_mode              <= fmt[cpt_pkg::FMT_ALAW];
        end
    end

    //------------------------------------------------------------------
    // Crossings into the link domain
    //------------------------------------------------------------------
    logic [3:0]  lk1;
    logic [3:0]  lk2;
    logic        tg3;
    logic [14:0] tx_hold;
    logic        en_l;
    logic        lin_l;
    logic        mute_l;

    assign en_l   = lk2[0];
    assign lin_l  = lk2[1];
    assign mute_l = lk2[2];

    // Quasi-static levels; the word itself moves by a toggle handshake.
    always_ff @(posedge i_pcm_bit_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            lk1     <= 4'h0;
            lk2     <= 4'h0;
            tg3     <= 1'b0;
            tx_hold <= 15'h0000;
        end else begin
            lk1 <= {tx_tgl, pwr.mic_mute_bit, fmt[cpt_pkg::FMT_LINEAR],
                    state == cpt_pkg::CPT_UP};
            lk2 <= lk1;
            tg3 <= lk2[3];
            if (lk2[3] != tg3) begin
                tx_hold <= tx_word;
            end
        end
    end

    //------------------------------------------------------------------
    // Transmit shifter
    //------------------------------------------------------------------
    logic [14:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic        tx_busy;
    logic        tx_last;
    logic [14:0] tx_load;

    always_comb begin
        tx_load = lin_l ? tx_hold : {tx_hold[7:0], 7'h00};
        if (mute_l) begin
            tx_load = 15'h0000; // see [R10]
        end
    end

    // Power is only looked at when a word starts, so a word in flight ends whole.
    always_ff @(posedge i_pcm_bit_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_sh   <= 15'h0000;
            tx_cnt  <= 4'h0;
            tx_busy <= 1'b0;
        end else if (i_pcm_frame_sync && en_l && !tx_busy) begin // see [R13]
            tx_sh   <= tx_load;
            tx_cnt  <= (lin_l ? cpt_pkg::LEN_LINEAR : cpt_pkg::LEN_COMPAND) - 4'h1;
            tx_busy <= 1'b1;
        end else if (tx_busy) begin // see [R7]
            if (tx_cnt == 4'h0) begin
                tx_busy <= 1'b0;
            end else begin
                tx_sh  <= {tx_sh[13:0], 1'b0}; // see [R15]
                tx_cnt <= tx_cnt - 4'h1;
            end
        end
    end

    always_ff @(negedge i_pcm_bit_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_last <= 1'b0;
        end else begin
            tx_last <= tx_busy && tx_cnt == 4'h0; // see [R14]
        end
    end

    assign o_pcm_serial_out    = tx_sh[14];
    assign o_pcm_serial_out_oe = tx_busy & ~tx_last; // see [R6] see [R14]

    //------------------------------------------------------------------
    // Receive shifter
    //------------------------------------------------------------------
    logic [14:0] rx_sh;
    logic [3:0]  rx_cnt;
    logic        rx_busy;
    logic [14:0] rx_word;
    logic        rx_tgl;

    always_ff @(negedge i_pcm_bit_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_sh   <= 15'h0000;
            rx_cnt  <= 4'h0;
            rx_busy <= 1'b0;
            rx_word <= 15'h0000;
            rx_tgl  <= 1'b0;
        end else if (i_pcm_frame_sync && en_l && !rx_busy) begin // see [R17]
            rx_sh   <= {14'h0000, i_pcm_serial_in};
            rx_cnt  <= (lin_l ? cpt_pkg::LEN_LINEAR : cpt_pkg::LEN_COMPAND) - 4'h2;
            rx_busy <= 1'b1;
        end else if (rx_busy) begin
            rx_sh <= {rx_sh[13:0], i_pcm_serial_in}; // see [R15]
            if (rx_cnt == 4'h0) begin
                rx_busy <= 1'b0;
                rx_word <= lin_l ? {rx_sh[13:0], i_pcm_serial_in}
                                 : {7'h00, rx_sh[6:0], i_pcm_serial_in};
                rx_tgl  <= ~rx_tgl;
            end else begin
                rx_cnt <= rx_cnt - 4'h1;
            end
        end
    end

    //------------------------------------------------------------------
    // Crossings back to the system domain
    //------------------------------------------------------------------
    logic rt1;
    logic rt2;
    logic rt3;
    logic tb1;

    assign rx_evt = rt2 != rt3;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rt1         <= 1'b0;
            rt2         <= 1'b0;
            rt3         <= 1'b0;
            tb1         <= 1'b0;
            tx_busy_s2  <= 1'b0;
            rx_word_sys <= 15'h0000;
            rx_new      <= 1'b0;
        end else begin
            rt1        <= rx_tgl;
            rt2        <= rt1;
            rt3        <= rt2;
            tb1        <= tx_busy;
            tx_busy_s2 <= tb1;
            if (rx_evt) begin
                rx_word_sys <= rx_word;
            end
            // A new word landing on the clearing read keeps the flag set.
            if (rx_evt) begin
                rx_new <= 1'b1;
            end else if (rd && i_wb_adr == cpt_pkg::ADR_RXW) begin
                rx_new <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    sequence s_word_start;
        i_pcm_frame_sync && en_l && !tx_busy;
    endsequence

    sequence s_txg_write;
        wr && i_wb_sel[0] && i_wb_adr == cpt_pkg::ADR_TXG;
    endsequence

    property p_reset_gain;
        @(posedge i_mclk) $rose(i_nrst) |-> txg.gain_code == 4'hB && !pwr.power_on;
    endproperty
    a_reset_gain: assert property (p_reset_gain) else $error("bad reset value"); // see [R2]

    property p_power_down;
        @(posedge i_mclk) disable iff (!i_nrst)
        !pwr.power_on |=> state == cpt_pkg::CPT_DOWN ##1 !o_powered;
    endproperty
    a_power_down: assert property (p_power_down) else $error("no power-down"); // see [R5]

    property p_clock_loss;
        @(posedge i_mclk) disable iff (!i_nrst)
        !mclk_ok && !txg.clk_override |=> ##1 !o_powered;
    endproperty
    a_clock_loss: assert property (p_clock_loss) else $error("up without clock"); // see [R6]

    property p_override;
        @(posedge i_mclk) disable iff (!i_nrst)
        pwr.power_on && txg.clk_override |=> ##1 o_powered;
    endproperty
    a_override: assert property (p_override) else $error("override ignored"); // see [R8]

    property p_earpath;
        @(posedge i_mclk) disable iff (!i_nrst)
        o_powered |-> o_diff_earphone_driver == $past(pwr.diff_ear)
                      && o_single_earphone_driver != o_diff_earphone_driver;
    endproperty
    a_earpath: assert property (p_earpath) else $error("earphone path wrong"); // see [R4]

    property p_gain_write;
        @(posedge i_mclk) disable iff (!i_nrst)
        s_txg_write ##0 (i_wb_dat[2:1] != 2'b11) |=> ##1 o_tx_gain_code == $past(i_wb_dat[3:0], 2)
                                             && o_extended_gain == !$past(i_wb_dat[3], 2);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain not taken"); // see [R3]

    property p_reserved;
        @(posedge i_mclk) disable iff (!i_nrst)
        s_txg_write ##0 (i_wb_dat[2:1] == 2'b11) |=> $stable(txg.gain_code);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code taken"); // see [R18]

    property p_word_len;
        @(posedge i_pcm_bit_clock) disable iff (!i_nrst)
        s_word_start ##0 !lin_l |=> tx_busy[*8] ##1 !tx_busy;
    endproperty
    a_word_len: assert property (p_word_len) else $error("companded length wrong"); // see [R9]

    property p_finish;
        @(posedge i_pcm_bit_clock) disable iff (!i_nrst)
        $fell(tx_busy) |-> $past(tx_cnt) == 4'h0;
    endproperty
    a_finish: assert property (p_finish) else $error("word cut short"); // see [R7]

    property p_release;
        @(negedge i_pcm_bit_clock) disable iff (!i_nrst)
        tx_busy && tx_cnt == 4'h0 |=> !o_pcm_serial_out_oe;
    endproperty
    a_release: assert property (p_release) else $error("output not released"); // see [R14]

endmodule

// *** pkg/cpt_pkg.sv ***
// Constants, register map and carrier types for the codec power and transmit control block.
//----------------------------------------------------------------------
// Overview of operation
// [R1] Host holds active-low reset at least 500 ns at power-on.
// [R2] Reset loads every control register with its default value.
// [R3] All settings may be written while the codec is powered down.
// [R4] Power control bit 1 picks differential (1) or single-ended (0) earphone.
// [R5] Clearing power control bit 0 powers down; override clear keeps clock watch.
// [R6] Master clock loss powers down and floats the PCM serial output.
// [R7] A word already being sent finishes before power-down takes effect.
// [R8] Transmit gain bit 7 ignores master clock loss when deciding power state.
// [R9] Word format is 15-bit linear or 8-bit mu-law or A-law.
// [R10] Power control bit 6 mutes the transmit channel.
// [R11] Gain codes 0-5 use extended stage, 8-13 normal stage, 2 dB steps.
// [R12] Gain code resets to 1011, the default total transmit gain.
// [R13] Each PCM output bit is driven after a bit clock rising edge.
// [R14] Output floats after the falling edge ending the last bit.
// [R15] PCM words travel most significant bit first in both directions.
// [R16] Host gives 256 or 16 bit clocks per frame sync period.
// [R17] Receive bits are sampled on bit clock falling edges.
// [R18] Gain codes 0110, 0111, 1110, 1111 are reserved and ignored.
//----------------------------------------------------------------------
package cpt_pkg;

    //------------------------------------------------------------------
    // Register map
    //------------------------------------------------------------------
    localparam logic [7:0] ADR_PWR  = 8'h00;
    localparam logic [7:0] ADR_TXG  = 8'h04;
    localparam logic [7:0] ADR_FMT  = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;
    localparam logic [7:0] ADR_TXW  = 8'h10;
    localparam logic [7:0] ADR_RXW  = 8'h14;

    localparam logic [7:0] RST_PWR = 8'h00;
    localparam logic [7:0] RST_TXG = 8'h0B;
    localparam logic [7:0] RST_FMT = 8'h00;

    // Format register fields.
    localparam int FMT_LINEAR = 0;
    localparam int FMT_ALAW   = 1;

    // Status register fields.
    localparam int ST_POWERED = 0;
    localparam int ST_MCLK_OK = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_RX_NEW  = 3;

    //------------------------------------------------------------------
    // Word lengths and timing
    //------------------------------------------------------------------
    localparam logic [3:0] LEN_LINEAR = 4'hF;
    localparam logic [3:0] LEN_COMPAND = 4'h8;
    localparam int CLK_NS       = 40;
    localparam int MCLK_LOSS_NS = 20000;
    localparam int MCLK_LOSS_CYC = MCLK_LOSS_NS / CLK_NS;
    localparam int RESET_MIN_NS = 500;

    //------------------------------------------------------------------
    // Carrier types
    //------------------------------------------------------------------
    typedef struct packed {
        logic       sidetone_mute;
        logic       mic_mute_bit;
        logic [1:0] rsv_hi;
        logic       ear_mute;
        logic       rsv_lo;
        logic       diff_ear;
        logic       power_on;
    } cpt_pwr_t;

    typedef struct packed {
        logic       clk_override;
        logic [2:0] rsv;
        logic [3:0] gain_code;
    } cpt_txg_t;

    typedef enum logic {
        CPT_DOWN = 1'b0,
        CPT_UP   = 1'b1
    } cpt_state_t;

endpackage

// *** verification/cpt_pcm_host.sv ***
// Behavioural host serial port that frames PCM words to and from the codec.
`timescale 1ns/1ns
module cpt_pcm_host (
    // Link lines driven toward the codec
    output logic      o_bit_clock,
    output logic      o_frame_sync,
    output logic      o_serial_in,
    // Link lines from the codec
    input  wire logic i_serial_out,
    input  wire logic i_serial_out_oe
);
    initial begin
        o_bit_clock = 1'b0;
        o_frame_sync = 1'b0;
        o_serial_in = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame
    // ------------------------------------------------------------
    // The clock stands still between frames, so the codec only sees edges here.
    task automatic frame(input logic [14:0] din, input int n, output logic [14:0] dout,
                         output int oe_cnt, output logic oe_end);
        dout = 15'h0;
        oe_cnt = 0;
        oe_end = 1'b0;
        for (int i = 0; i < 16; i++) begin
            o_frame_sync = (i == 0);
            // Past the word the line toggles every bit, so it no longer holds the last bit.
            o_serial_in = (i < n) ? din[n-1-i] : ~o_serial_in;
            #12 o_bit_clock = 1'b1;
            #23;
            if (i < n) begin
                dout = {dout[13:0], i_serial_out};
                oe_cnt += (i_serial_out_oe === 1'b1) ? 1 : 0;
            end
            #1 o_bit_clock = 1'b0;
            #6;
            if (i == n - 1) begin
                oe_end = i_serial_out_oe;
            end
            #6;
        end
    endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the codec power and transmit control block.
`timescale 1ns/1ns
module testbench;
    logic        mclk, nrst, cyc, stb, we, ack, codec_mclk, mclk_run;
    logic [7:0]  adr;
    logic [3:0]  sel, gain, cv, prev;
    logic [31:0] wdat, rdat, q;
    logic        bclk, fsync, sdi, sdo, sdo_oe, oe_end;
    logic        powered, diff_ear, single_ear, mic_mute, ear_mute, st_mute;
    logic        ext_gain, lin_mode, alaw_mode;
    logic [14:0] dout;
    int          oe_cnt, fail_count, comparisons;

    cpt_core DUT (
        .i_mclk(mclk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_codec_mclk(codec_mclk), .i_pcm_bit_clock(bclk), .i_pcm_frame_sync(fsync),
        .i_pcm_serial_in(sdi), .o_pcm_serial_out(sdo), .o_pcm_serial_out_oe(sdo_oe),
        .o_powered(powered), .o_diff_earphone_driver(diff_ear),
        .o_single_earphone_driver(single_ear), .o_mic_mute_bit(mic_mute),
        .o_ear_mute(ear_mute), .o_sidetone_mute(st_mute), .o_tx_gain_code(gain),
        .o_extended_gain(ext_gain), .o_linear_mode(lin_mode), .o_alaw_mode(alaw_mode)
    );
    cpt_pcm_host host (
        .o_bit_clock(bclk), .o_frame_sync(fsync), .o_serial_in(sdi),
        .i_serial_out(sdo), .i_serial_out_oe(sdo_oe)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (mclk_run) begin
            codec_mclk <= ~codec_mclk;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        chk("wb_ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic frame(input logic [14:0] din, input int n);
        host.frame(din, n, dout, oe_cnt, oe_end);
    endtask

    task automatic tx_check(input logic [31:0] exp, input int n);
        chk("tx_word", exp, {17'h0, dout});
        chk("tx_bits", n, oe_cnt);
        chk("oe_end", 32'h0, {31'h0, oe_end});
    endtask

    task automatic results;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        wb(1'b0, cpt_pkg::ADR_PWR, 32'h0);
        chk("pwr", {24'h0, cpt_pkg::RST_PWR}, q);
        wb(1'b0, cpt_pkg::ADR_TXG, 32'h0);
        chk("txg", 32'h0000000B, q);
        wb(1'b0, cpt_pkg::ADR_FMT, 32'h0);
        chk("fmt", {24'h0, cpt_pkg::RST_FMT}, q);
        chk("gain_out", 32'hB, {28'h0, gain});
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_gain;
        prev = 4'hB;
        for (int c = 0; c < 16; c++) begin
            cv = c[3:0];
            wb(1'b1, cpt_pkg::ADR_TXG, {28'h0, cv});
            if (cv[2:1] != 2'b11) begin
                prev = cv;
            end
            wb(1'b0, cpt_pkg::ADR_TXG, 32'h0);
            chk("txg_code", {28'h0, prev}, q);
            chk("gain_out", {28'h0, prev}, {28'h0, gain});
            chk("ext_gain", {31'h0, ~prev[3]}, {31'h0, ext_gain});
        end
    endtask

    task automatic t_power;
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h8B);
        repeat (4) @(posedge mclk);
        chk("powered", 32'h1, {31'h0, powered});
        chk("diff_ear", 32'h1, {31'h0, diff_ear});
        chk("single_ear", 32'h0, {31'h0, single_ear});
        chk("ear_st_mute", 32'h3, {30'h0, ear_mute, st_mute});
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h01);
        repeat (4) @(posedge mclk);
        chk("single_ear", 32'h1, {31'h0, single_ear});
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h00);
        repeat (4) @(posedge mclk);
        chk("powered", 32'h0, {31'h0, powered});
    endtask

    task automatic t_pcm;
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h01);
        wb(1'b1, cpt_pkg::ADR_TXW, 32'hA5);
        frame(15'h0, 8);
        frame(15'h3C, 8);
        tx_check(32'hA5, 8);
        wb(1'b0, cpt_pkg::ADR_RXW, 32'h0);
        chk("rx_word", 32'h3C, q);
        wb(1'b1, cpt_pkg::ADR_FMT, 32'h03);
        wb(1'b1, cpt_pkg::ADR_TXW, 32'h5A3C);
        chk("modes", 32'h3, {30'h0, alaw_mode, lin_mode});
        frame(15'h0, 15);
        frame(15'h1234, 15);
        tx_check(32'h5A3C, 15);
        wb(1'b0, cpt_pkg::ADR_RXW, 32'h0);
        chk("rx_word", 32'h1234, q);
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h41);
        frame(15'h0, 15);
        frame(15'h0, 15);
        tx_check(32'h0, 15);
        chk("mic_mute", 32'h1, {31'h0, mic_mute});
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h01);
        frame(15'h0, 15);
        // Power is withdrawn while the word is halfway out.
        fork
            frame(15'h0, 15);
            begin
                repeat (6) @(posedge mclk);
                wb(1'b1, cpt_pkg::ADR_PWR, 32'h00);
            end
        join
        tx_check(32'h5A3C, 15);
        frame(15'h0, 15);
        chk("tx_bits_down", 32'h0, oe_cnt);
    endtask

    task automatic t_clkloss;
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h01);
        repeat (4) @(posedge mclk);
        chk("powered", 32'h1, {31'h0, powered});
        mclk_run <= 1'b0;
        repeat (cpt_pkg::MCLK_LOSS_CYC + 20) @(posedge mclk);
        chk("powered", 32'h0, {31'h0, powered});
        wb(1'b0, cpt_pkg::ADR_STAT, 32'h0);
        // Only the unread word from the cut frame is still flagged.
        chk("status", 32'h8, q);
        frame(15'h0, 15);
        chk("tx_bits_lost", 32'h0, oe_cnt);
        wb(1'b1, cpt_pkg::ADR_TXG, 32'h8B);
        repeat (4) @(posedge mclk);
        chk("powered", 32'h1, {31'h0, powered});
        wb(1'b1, cpt_pkg::ADR_PWR, 32'h00);
        repeat (4) @(posedge mclk);
        chk("powered", 32'h0, {31'h0, powered});
    endtask

    initial begin
        nrst = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        codec_mclk = 1'b0;
        mclk_run = 1'b1;
        fail_count = 0;
        comparisons = 0;
        // Reset spans 13 cycles to meet the minimum width, with link edges inside it.
        fork
            frame(15'h0, 8);
            begin
                repeat (13) @(posedge mclk);
                nrst <= 1'b1;
            end
        join
        t_reset;
        t_gain;
        t_power;
        t_pcm;
        t_clkloss;
        results;
    end

    initial begin
        #400000;
        fail_count++;
        results;
    end
endmodule
